//--- inc/erase_regs_map.svh
`ifndef ERASE_REGS_MAP_SVH
`define ERASE_REGS_MAP_SVH
`define OFS_READY 12'h400
`define OFS_ACCESS_MODE 12'h504
`define OFS_PAGE_ERASE 12'h508
`define OFS_LEGACY_PAGE_ERASE 12'h510
`define OFS_USER_CONFIG_ERASE 12'h514
`define OFS_PARTIAL_PAGE_ERASE 12'h518
`define OFS_PARTIAL_ERASE_SETTINGS 12'h51c
`define MODE_READ_ONLY 2'h0
`define MODE_WRITE_EN 2'h1
`define MODE_ERASE_EN 2'h2
`define RST_WORD 32'h0000_0000
`define RST_PARTIAL_CFG 32'h0000_000a
`define ERASE_TIME_NS 1000
`define PARTIAL_TIME_NS 500
`define UCFG_TIME_NS 2000
`define CLK_PERIOD_NS 10
`endif

//--- inc/erase_regs_pkg.sv
package erase_regs_pkg;
  typedef enum logic [1:0] {OP_PAGE, OP_PARTIAL, OP_UCFG} erase_op_e;
  typedef struct packed {
    logic       start;
    erase_op_e  op;
    logic [31:0] addr;
  } erase_req_s;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_s;
endpackage

//--- rtl/erase_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "erase_regs_map.svh"
module erase_engine
  import erase_regs_pkg::*;
#(
  parameter int PAGE_CYC = `ERASE_TIME_NS / `CLK_PERIOD_NS,
  parameter int UCFG_CYC = `UCFG_TIME_NS / `CLK_PERIOD_NS,
  parameter int PART_CYC = `PARTIAL_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Request
  input wire erase_req_s req,
  // Status
  output logic busy,
  output logic [31:0] last_addr
);
  typedef enum logic {IDLE, RUN} eng_e;
  eng_e st_r;
  logic [31:0] cnt_r;

  function automatic logic [31:0] op_len(input erase_op_e op);
    case (op)
      OP_UCFG: op_len = 32'(UCFG_CYC);
      OP_PARTIAL: op_len = 32'(PART_CYC);
      default: op_len = 32'(PAGE_CYC);
    endcase
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r <= IDLE;
      cnt_r <= `RST_WORD;
    end else begin
      case (st_r)
        IDLE: begin
          if (req.start) begin
            st_r <= RUN;
            cnt_r <= op_len(req.op) - 32'h1;
          end
        end
        RUN: begin
          if (cnt_r == `RST_WORD) begin
            st_r <= IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        default: st_r <= IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_addr <= `RST_WORD;
    end else if (req.start && st_r == IDLE) begin
      last_addr <= req.addr;
    end
  end

  assign busy = (st_r == RUN);
endmodule
`default_nettype wire

//--- rtl/erase_regs.sv
// Operation
// - A write at 0x510 starts a code-area page erase exactly like the page erase register.
// - Writing 1 to the user-config erase field erases the whole config area; 0 does nothing.
// - A write at 0x518 takes the value as page start address and starts a partial erase.
// - A separate register at 0x51c holds the partial erase settings.
// - Access mode encodes read-only 0, write enabled 1, erase enabled 2.
// - Ready reads 0 while an erase runs and 1 when idle.
`timescale 1ns/1ps
`default_nettype none
`include "erase_regs_map.svh"
module erase_regs
  import erase_regs_pkg::*;
#(
  parameter int PAGE_CYC = `ERASE_TIME_NS / `CLK_PERIOD_NS,
  parameter int UCFG_CYC = `UCFG_TIME_NS / `CLK_PERIOD_NS,
  parameter int PART_CYC = `PARTIAL_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Flash side status
  output logic erase_busy,
  output logic [31:0] erase_addr,
  output logic [1:0] erase_op,
  output logic [1:0] access_mode
);
  logic [1:0] mode_r;
  logic [31:0] page_r;
  logic [31:0] ucfg_r;
  logic [31:0] part_r;
  logic [31:0] pcfg_r;
  logic [31:0] rdata_r;
  logic busy_r;
  logic [31:0] eaddr_r;
  logic [1:0] eop_r;
  erase_req_s req;
  logic eng_busy;
  logic [31:0] eng_addr;
  logic erase_ok;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  assign erase_ok = (mode_r == `MODE_ERASE_EN) && !eng_busy;

  // Launch decode
  always_comb begin
    req = '0;
    req.op = OP_PAGE;
    if (wr_en && erase_ok) begin
      if (hit(addr, `OFS_PAGE_ERASE) || hit(addr, `OFS_LEGACY_PAGE_ERASE)) begin
        req.start = 1'b1;
        req.addr = wdata;
      end else if (hit(addr, `OFS_USER_CONFIG_ERASE) && wdata[0]) begin
        req.start = 1'b1;
        req.op = OP_UCFG;
      end else if (hit(addr, `OFS_PARTIAL_PAGE_ERASE)) begin
        req.start = 1'b1;
        req.op = OP_PARTIAL;
        req.addr = wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= `MODE_READ_ONLY;
    end else if (wr_en && hit(addr, `OFS_ACCESS_MODE) && wdata[1:0] != 2'h3) begin
      mode_r <= wdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      page_r <= `RST_WORD;
      ucfg_r <= `RST_WORD;
      part_r <= `RST_WORD;
    end else if (wr_en) begin
      if (hit(addr, `OFS_PAGE_ERASE) || hit(addr, `OFS_LEGACY_PAGE_ERASE)) begin
        page_r <= wdata;
      end
      if (hit(addr, `OFS_USER_CONFIG_ERASE)) begin
        ucfg_r <= {31'h0, wdata[0]};
      end
      if (hit(addr, `OFS_PARTIAL_PAGE_ERASE)) begin
        part_r <= wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pcfg_r <= `RST_PARTIAL_CFG;
    end else if (wr_en && hit(addr, `OFS_PARTIAL_ERASE_SETTINGS)) begin
      pcfg_r <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= `RST_WORD;
    end else if (rd_en) begin
      case (addr)
        `OFS_READY: rdata_r <= {31'h0, ~eng_busy};
        `OFS_ACCESS_MODE: rdata_r <= {30'h0, mode_r};
        `OFS_PAGE_ERASE: rdata_r <= page_r;
        `OFS_LEGACY_PAGE_ERASE: rdata_r <= page_r;
        `OFS_USER_CONFIG_ERASE: rdata_r <= ucfg_r;
        `OFS_PARTIAL_PAGE_ERASE: rdata_r <= part_r;
        `OFS_PARTIAL_ERASE_SETTINGS: rdata_r <= pcfg_r;
        default: rdata_r <= `RST_WORD;
      endcase
    end else begin
      rdata_r <= `RST_WORD;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      eaddr_r <= `RST_WORD;
      eop_r <= 2'h0;
    end else begin
      busy_r <= eng_busy;
      eaddr_r <= eng_addr;
      if (req.start) begin
        eop_r <= req.op;
      end
    end
  end

  erase_engine #(
    .PAGE_CYC(PAGE_CYC),
    .UCFG_CYC(UCFG_CYC),
    .PART_CYC(PART_CYC)
  ) u_engine (
    .mclk(mclk),
    .resetn(resetn),
    .req(req),
    .busy(eng_busy),
    .last_addr(eng_addr)
  );

  assign rdata = rdata_r;
  assign erase_busy = busy_r;
  assign erase_addr = eaddr_r;
  assign erase_op = eop_r;
  assign access_mode = mode_r;
endmodule
`default_nettype wire

//--- verification/erase_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module erase_regs_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // Status
  input wire logic erase_busy,
  input wire logic [31:0] erase_addr,
  input wire logic [1:0] erase_op,
  input wire logic [1:0] access_mode
);
  logic go;
  assign go = wr_en && access_mode == 2'h2 && !erase_busy;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_MODE: assert property (wr_en && addr == 12'h504 && wdata[1:0] != 2'h3
    |=> access_mode == 2'($past(wdata))) else $error("mode not stored");
  AST_PAGE: assert property (go && !$past(wr_en) && (addr == 12'h510 || addr == 12'h508)
    |-> ##2
    erase_busy && erase_op == 2'h0 && erase_addr == $past(wdata, 2)) else $error("page");
  AST_UCFG: assert property (go && !$past(wr_en) && addr == 12'h514 && wdata[0]
    |-> ##2 erase_busy && erase_op == 2'h2) else $error("config erase");
  AST_UNOP: assert property (go && !$past(wr_en) && addr == 12'h514 && !wdata[0]
    |=> !erase_busy ##1 !erase_busy) else $error("config no-op");
  AST_PART: assert property (go && !$past(wr_en) && addr == 12'h518 |-> ##2
    erase_busy && erase_op == 2'h1 && erase_addr == $past(wdata, 2)) else $error("partial");
  AST_READY: assert property (rd_en && addr == 12'h400
    |=> rdata == {31'h0, !erase_busy}) else $error("ready");
  AST_CFG: assert property (wr_en && addr == 12'h51c ##1 !wr_en ##1 rd_en && addr == 12'h51c
    |=> rdata == $past(wdata, 3)) else $error("settings");
endmodule
bind erase_regs erase_regs_asserts erase_regs_asserts_inst (.mclk(mclk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .erase_busy(erase_busy), .erase_addr(erase_addr), .erase_op(erase_op),
  .access_mode(access_mode));
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, resetn = 0, wr_en = 0, rd_en = 0, erase_busy;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, erase_addr;
  logic [1:0] erase_op, access_mode;
  int error_cnt = 0, samples_checked = 0;
  always #5 mclk = ~mclk;
  erase_regs #(.PAGE_CYC(3), .UCFG_CYC(5), .PART_CYC(4)) erase_regs_inst (.mclk(mclk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .erase_busy(erase_busy), .erase_addr(erase_addr),
    .erase_op(erase_op), .access_mode(access_mode));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task rc(logic [11:0] a, logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, e);
  endtask
  task erase(logic [11:0] a, logic [31:0] d, logic [1:0] op);
    wr(12'h504, 32'h2);
    wr(a, d);
    rc(12'h400, 32'h0);
    chk("busy", {31'h0, erase_busy}, 32'h1);
    repeat (20) @(posedge mclk);
    rc(12'h400, 32'h1);
    chk("idle", {31'h0, erase_busy}, 32'h0);
    chk("op", {30'h0, erase_op}, {30'h0, op});
    if (op != 2'h2) chk("addr", erase_addr, d);
    wr(12'h504, 32'h0);
  endtask
  task t_regs;
    rc(12'h510, 32'h0);
    rc(12'h514, 32'h0);
    rc(12'h518, 32'h0);
    rc(12'h51c, 32'ha);
    rc(12'h7fc, 32'h0);
    rc(12'h504, 32'h0);
    rc(12'h400, 32'h1);
    $display("t_regs done");
  endtask
  task t_mode;
    for (int m = 0; m < 3; m++) begin
      wr(12'h504, 32'(m));
      rc(12'h504, 32'(m));
      chk("mode", {30'h0, access_mode}, 32'(m));
    end
    wr(12'h504, 32'h3);
    rc(12'h504, 32'h2);
    chk("mode", {30'h0, access_mode}, 32'h2);
    wr(12'h51c, 32'h5a5a0003);
    rc(12'h51c, 32'h5a5a0003);
    $display("t_mode done");
  endtask
  task t_refuse;
    wr(12'h504, 32'h0);
    wr(12'h510, 32'h1000);
    rc(12'h400, 32'h1);
    rc(12'h510, 32'h1000);
    $display("t_refuse done");
  endtask
  task t_ucfg;
    wr(12'h504, 32'h2);
    wr(12'h514, 32'h0);
    rc(12'h400, 32'h1);
    erase(12'h514, 32'h1, 2'h2);
    $display("t_ucfg done");
  endtask
  task t_erases;
    erase(12'h518, 32'h3000, 2'h1);
    rc(12'h518, 32'h3000);
    erase(12'h510, 32'h2000, 2'h0);
    erase(12'h508, 32'h4000, 2'h0);
    rc(12'h510, 32'h4000);
    $display("t_erases done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    t_regs;
    t_mode;
    t_refuse;
    t_ucfg;
    t_erases;
    close_out;
  end
  initial begin
    #100000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
